/* led_ind_pkg.sv */
// constants and types for the front-panel indicator controller
// Functional notes
// - access point receive LED blinks while receiving
// - one red error blink for either fault
// - link lit when attached; speed only 100M
// - normal mode push transmit lights steady
// - battery power: level bar and push transmit off after 15s
// - site survey push transmit lights steady
// - four segments at 80-100% or full
// - three segments at 60-80% or good
// - two segments at 40-60% or moderate
// - one segment at 20-40% or poor
// - no segments below 20% or none
package led_ind_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned FAST_HZ = 2;
	localparam int unsigned ERR_FAST_HZ = 4;
	localparam int unsigned SLOW_DIV = 2;
	localparam int unsigned OFF_SECS = 15;
	localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
	localparam int unsigned ERR_HALF_CYC = CLK_HZ / (2 * ERR_FAST_HZ);
	localparam longint unsigned OFF_CYC = longint'(OFF_SECS) * longint'(CLK_HZ);
	// ----------------------------------------
	// level thresholds, percent
	// ----------------------------------------
	localparam logic [6:0] LVL_FOUR = 7'h50;
	localparam logic [6:0] LVL_THREE = 7'h3c;
	localparam logic [6:0] LVL_TWO = 7'h28;
	localparam logic [6:0] LVL_ONE = 7'h14;
	localparam logic [3:0] BAR_SEG1 = 4'h1;
	localparam logic [3:0] BAR_SEG2 = 4'h2;
	// ----------------------------------------
	// modes and signal grades
	// ----------------------------------------
	typedef enum logic [1:0] {MODE_NORMAL, MODE_SURVEY, MODE_UPDATE} mode_t;
	typedef enum logic [2:0] {SIG_NONE, SIG_POOR, SIG_MODERATE, SIG_GOOD, SIG_FULL} sig_t;
endpackage

/* led_indicator_controller.sv */
// indicator LED controller for sensor node and access point
`timescale 1ns/10ps
module led_indicator_controller import led_ind_pkg::*; #(
	parameter longint unsigned OFF_CYCLES = OFF_CYC,
	parameter int unsigned FAST_HALF = FAST_HALF_CYC,
	parameter int unsigned ERR_HALF = ERR_HALF_CYC
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic CE_I,
	input wire logic [1:0] MODE_I,
	input wire logic INIT_I,
	input wire logic PUSH_CFG_I,
	input wire logic NODE_TX_I,
	input wire logic UPD_RX_I,
	input wire logic UPD_TX_I,
	input wire logic ON_BATTERY_I,
	input wire logic BATT_LOW_I,
	input wire logic SHOW_SIGNAL_I,
	input wire logic [6:0] BATT_PCT_I,
	input wire logic [2:0] SIG_GRADE_I,
	input wire logic RF_FAULT_I,
	input wire logic IO_FAULT_I,
	input wire logic AP_RX_ACT_I,
	input wire logic LAN_LINK_I,
	input wire logic LAN_100M_I,
	output logic STATUS_GRN_O,
	output logic STATUS_RED_O,
	output logic ERR_RED_O,
	output logic RX_GRN_O,
	output logic TX_GRN_O,
	output logic [3:0] LEVEL_YEL_O,
	output logic AP_STATUS_O,
	output logic AP_ERR_O,
	output logic AP_RX_O,
	output logic LINK_GRN_O,
	output logic SPEED_YEL_O
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NIN = 25;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1_r;
	logic [NIN-1:0] s2_r;
	assign raw = {MODE_I, INIT_I, PUSH_CFG_I, NODE_TX_I, UPD_RX_I, UPD_TX_I, ON_BATTERY_I,
		BATT_LOW_I, SHOW_SIGNAL_I, BATT_PCT_I, SIG_GRADE_I, RF_FAULT_I, IO_FAULT_I,
		AP_RX_ACT_I, LAN_LINK_I, LAN_100M_I};
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s1_r <= '0;
			s2_r <= '0;
		end else if (CE_I) begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	logic [1:0] mode;
	logic init, push_cfg, node_tx, upd_rx, upd_tx, on_batt, batt_low, show_sig;
	logic [6:0] batt_pct;
	logic [2:0] sig_grade;
	logic rf_flt, io_flt, ap_rx, lan_link, lan_100m;
	logic [1:0] mode_w;
	logic [6:0] pct_w;
	logic [2:0] grade_w;
	logic [1:0] mode_r;
	logic [6:0] pct_r;
	logic [2:0] grade_r;
	assign {mode_w, init, push_cfg, node_tx, upd_rx, upd_tx, on_batt, batt_low, show_sig,
		pct_w, grade_w, rf_flt, io_flt, ap_rx, lan_link, lan_100m} = s2_r;
	// words taken only when both stages agree: bit skew never shows a mixed value,
	// at the cost of one more cycle of latency
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			mode_r <= '0;
			pct_r <= '0;
			grade_r <= '0;
		end else if (CE_I) begin
			if (s1_r[24:23] == mode_w) mode_r <= mode_w;
			if (s1_r[14:8] == pct_w) pct_r <= pct_w;
			if (s1_r[7:5] == grade_w) grade_r <= grade_w;
		end
	end
	assign mode = mode_r;
	assign batt_pct = pct_r;
	assign sig_grade = grade_r;

	// ----------------------------------------
	// blink timebase
	// ----------------------------------------
	// one counter for 2 Hz, 0.5 Hz derived by dividing it, keeps phases aligned
	logic [31:0] fast_cnt_r;
	logic fast_ph_r;
	// slow half period is four fast halves
	logic [SLOW_DIV:0] slow_cnt_r;
	logic [31:0] err_cnt_r;
	logic err_ph_r;
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			fast_cnt_r <= '0;
			fast_ph_r <= 1'b0;
			slow_cnt_r <= '0;
		end else if (CE_I) begin
			if (fast_cnt_r == FAST_HALF - 1) begin
				fast_cnt_r <= '0;
				fast_ph_r <= ~fast_ph_r;
				slow_cnt_r <= slow_cnt_r + 3'h1;
			end else begin
				fast_cnt_r <= fast_cnt_r + 32'h1;
			end
		end
	end
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			err_cnt_r <= '0;
			err_ph_r <= 1'b0;
		end else if (CE_I) begin
			if (err_cnt_r == ERR_HALF - 1) begin
				err_cnt_r <= '0;
				err_ph_r <= ~err_ph_r;
			end else begin
				err_cnt_r <= err_cnt_r + 32'h1;
			end
		end
	end
	logic slow_ph;
	assign slow_ph = slow_cnt_r[SLOW_DIV];

	// ----------------------------------------
	// battery auto-off
	// ----------------------------------------
	// restarts on mode change; external supply keeps indicators on
	logic [39:0] off_cnt_r;
	logic [1:0] mode_prev_r;
	logic lit_r;
	logic ind_en;
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			off_cnt_r <= '0;
			mode_prev_r <= '0;
			lit_r <= 1'b1;
		end else if (CE_I) begin
			mode_prev_r <= mode;
			if (!on_batt || mode != mode_prev_r) begin
				off_cnt_r <= '0;
				lit_r <= 1'b1;
			end else if (off_cnt_r >= OFF_CYCLES - 1) begin
				lit_r <= 1'b0;
			end else begin
				off_cnt_r <= off_cnt_r + 40'h1;
			end
		end
	end
	assign ind_en = lit_r;

	// ----------------------------------------
	// level bar
	// ----------------------------------------
	function automatic logic [3:0] bar_of_pct(input logic [6:0] p);
		if (p >= LVL_FOUR) return 4'hf;
		else if (p >= LVL_THREE) return 4'h7;
		else if (p >= LVL_TWO) return 4'h3;
		else if (p >= LVL_ONE) return 4'h1;
		else return 4'h0;
	endfunction
	function automatic logic [3:0] bar_of_sig(input logic [2:0] g);
		unique case (sig_t'(g))
			SIG_FULL: return 4'hf;
			SIG_GOOD: return 4'h7;
			SIG_MODERATE: return 4'h3;
			SIG_POOR: return 4'h1;
			default: return 4'h0;
		endcase
	endfunction

	// ----------------------------------------
	// node indicator outputs
	// ----------------------------------------
	logic [3:0] bar;
	logic [3:0] flt_seg;
	assign bar = show_sig ? bar_of_sig(sig_grade) : bar_of_pct(batt_pct);
	assign flt_seg = rf_flt ? BAR_SEG1 : (io_flt ? BAR_SEG2 : 4'h0);

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			STATUS_GRN_O <= 1'b0;
			STATUS_RED_O <= 1'b0;
			ERR_RED_O <= 1'b0;
			RX_GRN_O <= 1'b0;
			TX_GRN_O <= 1'b0;
			LEVEL_YEL_O <= 4'h0;
		end else if (CE_I) begin
			if (mode_t'(mode) == MODE_SURVEY) STATUS_GRN_O <= 1'b1;
			else if (init) STATUS_GRN_O <= fast_ph_r;
			else if (push_cfg && mode_t'(mode) == MODE_NORMAL) STATUS_GRN_O <= slow_ph;
			else STATUS_GRN_O <= 1'b0;
			STATUS_RED_O <= batt_low & slow_ph;
			ERR_RED_O <= (rf_flt | io_flt) & err_ph_r;
			RX_GRN_O <= (mode_t'(mode) == MODE_UPDATE) & upd_rx;
			if (mode_t'(mode) == MODE_UPDATE) TX_GRN_O <= upd_tx;
			else TX_GRN_O <= push_cfg & node_tx & ind_en;
			if (!ind_en) LEVEL_YEL_O <= 4'h0;
			else if (flt_seg != 4'h0) LEVEL_YEL_O <= (bar & ~flt_seg) | (flt_seg & {4{err_ph_r}});
			else LEVEL_YEL_O <= bar;
		end
	end

	// ----------------------------------------
	// access point outputs
	// ----------------------------------------
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			AP_STATUS_O <= 1'b0;
			AP_ERR_O <= 1'b0;
			AP_RX_O <= 1'b0;
			LINK_GRN_O <= 1'b0;
			SPEED_YEL_O <= 1'b0;
		end else if (CE_I) begin
			AP_STATUS_O <= slow_ph;
			AP_ERR_O <= (rf_flt | io_flt) & fast_ph_r;
			AP_RX_O <= ap_rx & fast_ph_r;
			LINK_GRN_O <= lan_link;
			SPEED_YEL_O <= lan_link & lan_100m;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_speed;
		@(posedge CLK_I) disable iff (!NRST_I)
		CE_I ##1 CE_I |-> (SPEED_YEL_O == ($past(s2_r[1]) & $past(s2_r[0])));
	endproperty
	a_speed: assert property (p_speed) else $error("speed led wrong");
	property p_link;
		@(posedge CLK_I) disable iff (!NRST_I) CE_I |=> LINK_GRN_O == $past(lan_link);
	endproperty
	a_link: assert property (p_link) else $error("link led wrong");
	property p_aperr;
		@(posedge CLK_I) disable iff (!NRST_I) CE_I && !rf_flt && !io_flt |=> !AP_ERR_O;
	endproperty
	a_aperr: assert property (p_aperr) else $error("error led without fault");
	property p_aprx;
		@(posedge CLK_I) disable iff (!NRST_I) CE_I && !ap_rx |=> !AP_RX_O;
	endproperty
	a_aprx: assert property (p_aprx) else $error("rx led without traffic");
	property p_tx;
		@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && mode_t'(mode) != MODE_UPDATE && push_cfg && node_tx && lit_r |=> TX_GRN_O;
	endproperty
	a_tx: assert property (p_tx) else $error("tx led not lit");
	property p_full;
		@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && lit_r && !show_sig && batt_pct >= LVL_FOUR && !rf_flt && !io_flt
		|=> LEVEL_YEL_O == 4'hf;
	endproperty
	a_full: assert property (p_full) else $error("bar not full");
	property p_low;
		@(posedge CLK_I) disable iff (!NRST_I)
		CE_I && !show_sig && batt_pct < LVL_ONE && !rf_flt && !io_flt |=> LEVEL_YEL_O == 4'h0;
	endproperty
	a_low: assert property (p_low) else $error("bar not dark");
	property p_survey;
		@(posedge CLK_I) disable iff (!NRST_I) CE_I && mode_t'(mode) == MODE_SURVEY |=> STATUS_GRN_O;
	endproperty
	a_survey: assert property (p_survey) else $error("survey status not steady");
	property p_off;
		@(posedge CLK_I) disable iff (!NRST_I) !lit_r && CE_I |=> LEVEL_YEL_O == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("bar lit after timeout");
	c_timeout: cover property (@(posedge CLK_I) disable iff (!NRST_I) $fell(lit_r));
	c_upd: cover property (@(posedge CLK_I) disable iff (!NRST_I) RX_GRN_O && TX_GRN_O);
	c_fault: cover property (@(posedge CLK_I) disable iff (!NRST_I) ERR_RED_O && LEVEL_YEL_O[0]);

endmodule // led_indicator_controller

/* led_indicator_controller_tb.sv */
// self-checking bench for the indicator controller
`timescale 1ns/10ps
module led_indicator_controller_tb import led_ind_pkg::*; ;
	logic clk = 0, nrst = 0, init = 0, push = 0, ntx = 0, urx = 0, utx = 0;
	logic batt = 0, blow = 0, shows = 0, rf = 0, io = 0, aprx = 0, lnk = 0, l100 = 0;
	logic clr = 0;
	logic ce = 1;
	logic [1:0] mode = 2'h0;
	logic [6:0] pct = 7'h00;
	logic [2:0] sg = 3'h0;
	wire [13:0] led;
	int tog [14];
	int error_cnt = 0, checked = 0, cyc = 0;
	// ----
	// design and lamps
	// ----
	// short counts keep the run brief; expectations use these values
	led_indicator_controller #(.OFF_CYCLES(100), .FAST_HALF(8), .ERR_HALF(4)) uut (
		.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .MODE_I(mode), .INIT_I(init),
		.PUSH_CFG_I(push), .NODE_TX_I(ntx), .UPD_RX_I(urx), .UPD_TX_I(utx),
		.ON_BATTERY_I(batt), .BATT_LOW_I(blow), .SHOW_SIGNAL_I(shows), .BATT_PCT_I(pct),
		.SIG_GRADE_I(sg), .RF_FAULT_I(rf), .IO_FAULT_I(io), .AP_RX_ACT_I(aprx),
		.LAN_LINK_I(lnk), .LAN_100M_I(l100), .STATUS_GRN_O(led[13]), .STATUS_RED_O(led[12]),
		.ERR_RED_O(led[11]), .RX_GRN_O(led[10]), .TX_GRN_O(led[9]), .LEVEL_YEL_O(led[8:5]),
		.AP_STATUS_O(led[4]), .AP_ERR_O(led[3]), .AP_RX_O(led[2]), .LINK_GRN_O(led[1]),
		.SPEED_YEL_O(led[0]));
	led_panel_model panel (.clk_i(clk), .clr_i(clr), .led_i(led), .tog_o(tog));
	initial forever #2 clk = ~clk;
	// ----
	// helpers
	// ----
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task cw(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task watch(input int n);
		clr = 1;
		cw(1);
		clr = 0;
		cw(n);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task t_lan;
		lnk = 1; l100 = 1; cw(4);
		chk("link", led[1:0], 2'h3);
		l100 = 0; cw(4);
		chk("link 10M", led[1:0], 2'h2);
		lnk = 0; cw(4);
		chk("unlinked", led[1], 1'b0);
	endtask
	task t_ce;
		ce = 0;
		lnk = 1;
		l100 = 1;
		cw(6);
		chk("frozen link", led[1:0], 2'h0);
		ce = 1;
		cw(4);
		chk("thawed link", led[1:0], 2'h3);
		lnk = 0;
		l100 = 0;
		cw(4);
	endtask
	task t_bar;
		logic [6:0] p [10] = '{7'h64, 7'h50, 7'h4f, 7'h3c, 7'h3b, 7'h28, 7'h27, 7'h14, 7'h13, 7'h00};
		int n [10] = '{4, 4, 3, 3, 2, 2, 1, 1, 0, 0};
		for (int i = 0; i < 10; i++) begin
			pct = p[i]; cw(4);
			chk("bar batt", led[8:5], (1 << n[i]) - 1);
		end
		shows = 1;
		for (int g = 0; g < 5; g++) begin
			sg = g[2:0]; cw(4);
			chk("bar sig", led[8:5], (1 << g) - 1);
		end
		shows = 0;
	endtask
	task t_ap;
		aprx = 1; watch(40);
		chk("ap rx blink", tog[2] >= 2, 1);
		aprx = 0; cw(4); watch(40);
		chk("ap rx idle", tog[2] + led[2], 0);
		rf = 1; watch(40);
		chk("ap err rf", tog[3] >= 2, 1);
		chk("rf seg one", (tog[11] >= 2) && (tog[5] >= 2) && (tog[6] == 0), 1);
		rf = 0; io = 1; cw(4); watch(40);
		chk("ap err io", tog[3] >= 2, 1);
		chk("io seg two", (tog[11] >= 2) && (tog[6] >= 2) && (tog[5] == 0), 1);
		io = 0; cw(40);
	endtask
	task t_tx;
		mode = 2'h0; push = 1; ntx = 1; cw(4); watch(30);
		chk("tx normal", {led[9], tog[9] == 0}, 2'h3);
		mode = 2'h1; cw(4); watch(30);
		chk("tx survey", {led[9], tog[9] == 0}, 2'h3);
		chk("status survey", {led[13], tog[13] == 0}, 2'h3);
		mode = 2'h0; push = 0; cw(4);
		chk("tx no push", led[9], 1'b0);
	endtask
	task t_off;
		push = 1; pct = 7'h64; batt = 1; cw(60);
		chk("tx on batt", led[9], 1'b1);
		cw(80);
		chk("auto off", {led[9], led[8:5]}, 5'h00);
		batt = 0; cw(150);
		chk("external supply", {led[9], led[8:5]}, 5'h1f);
	endtask
	task t_stat;
		push = 0; init = 1; cw(4); watch(32);
		chk("status init", tog[13], 4);
		init = 0; push = 1; cw(4); watch(64);
		chk("status push", tog[13], 2);
		chk("ap status", tog[4], 2);
		blow = 1; cw(4); watch(64);
		chk("low batt red", tog[12], 2);
		blow = 0; mode = 2'h2; urx = 1; ntx = 0; cw(4);
		chk("update rx", led[10:9], 2'h2);
		urx = 0; utx = 1; cw(4);
		chk("update tx", led[10:9], 2'h1);
	endtask
	// ----
	// run and watchdog
	// ----
	initial begin
		cw(10);
		nrst = 1;
		cw(2);
		t_lan; t_ce; t_bar; t_ap; t_tx; t_off; t_stat;
		report_and_stop;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop;
		end
	end
endmodule // led_indicator_controller_tb

/* led_panel_model.sv */
// model of the discrete front-panel LEDs, counting blink toggles
`timescale 1ns/10ps
module led_panel_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic [13:0] led_i,
	output int tog_o [14]
);
	logic [13:0] last_r;
	// ----
	// toggle counters
	// ----
	// a lamp has no memory; only level changes are seen by the viewer
	always @(posedge clk_i) begin
		last_r <= led_i;
		for (int i = 0; i < 14; i++) begin
			if (clr_i)
				tog_o[i] <= 0;
			else if (led_i[i] !== last_r[i])
				tog_o[i] <= tog_o[i] + 1;
		end
	end
endmodule // led_panel_model
